// ---- hdl/ud_consts.svh ----
`ifndef UD_CONSTS_SVH
`define UD_CONSTS_SVH

// Register byte addresses.
`define UD_ADDR_DATA      32'h5000_1000
`define UD_ADDR_DIV_HIGH  32'h5000_1004
`define UD_ADDR_FIFO_CTRL 32'h5000_1008
`define UD_ADDR_LINE_FMT  32'h5000_100C
`define UD_ADDR_LINE_ST   32'h5000_1014
`define UD_ADDR_IRQ_STAT  32'h5000_1040
`define UD_ADDR_IRQ_MASK  32'h5000_1044

// Field positions.
`define UD_FMT_DIV_ACCESS 7
`define UD_FMT_IR_MODE    0
`define UD_FIFO_ENABLE    0
`define UD_ST_RX_READY    0
`define UD_ST_OVERRUN     1
`define UD_ST_TX_EMPTY    5
`define UD_ST_TX_IDLE     6
`define UD_IRQ_RX         0
`define UD_IRQ_OVERRUN    1
`define UD_IRQ_TX         2

// Reset values.
`define UD_RST_DIV        16'h0000
`define UD_RST_LINE_FMT   8'h00
`define UD_RST_IRQ_MASK   3'h0

// Timing counts, in ticks of the sixteen-fold baud clock.
`define UD_TICKS_LAST     4'hF
`define UD_TICKS_MID      4'h7
`define UD_IR_PULSE       4'h3

// Bus answers.
`define UD_RESP_OKAY      2'b00
`define UD_RESP_SLVERR    2'b10

`endif

// ---- hdl/ud_pkg.sv ----
package ud_pkg;

  // Shared by the transmit and receive sequencers.
  typedef enum logic [1:0] {
    UD_IDLE  = 2'b00,
    UD_START = 2'b01,
    UD_DATA  = 2'b10,
    UD_STOP  = 2'b11
  } ud_state_t;

endpackage : ud_pkg

// ---- hdl/ud_fifo.sv ----
`timescale 1ns/1ps
module ud_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk_i,       // Bus clock.
  input  wire logic                       rst_i,       // Async reset.
  input  wire logic                       flush_i,     // Drop all entries.
  input  wire logic                       in_valid_i,  // Entry offered.
  output logic                            in_ready_o,  // Room left.
  input  wire logic [WIDTH-1:0]           in_data_i,   // Entry in.
  output logic                            out_valid_o, // Entry held.
  input  wire logic                       out_ready_i, // Entry taken.
  output logic [WIDTH-1:0]                out_data_o,  // Oldest entry.
  output logic [$clog2(DEPTH+1)-1:0]      count_o      // Fill level.
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;

  // Handshakes and pointer wrap; depth need not be a power of two.
  wire          push        = in_valid_i && in_ready_o;
  wire          pop         = out_valid_o && out_ready_i;
  wire [AW-1:0] next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
  assign in_ready_o  = count_o != CW'(DEPTH);
  assign out_valid_o = count_o != '0;
  assign out_data_o  = mem[rd_ptr];

  // Storage carries no reset; only the pointers and the level define what is valid.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and level.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count_o <= '0;
    end else if (flush_i) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count_o <= '0;
    end else begin
      if (push) wr_ptr <= next_wr_ptr;
      if (pop) rd_ptr <= next_rd_ptr;
      count_o <= count_o + CW'(push) - CW'(pop);
    end
  end

endmodule : ud_fifo

// ---- hdl/ud_top.sv ----
// How it works
// R01: A data read returns the last character received, from rxd or infrared.
// R02: Software trusts received data only while the ready flag is set.
// R03: Without FIFOs a new character overwrites an unread one and flags overrun.
// R04: With FIFOs a data read returns the oldest receive FIFO entry.
// R05: A character hitting a full receive FIFO is dropped and flags overrun.
// R06: A written byte leaves on txd, or on the low-active infrared output.
// R07: Software writes transmit data only while transmit-empty is set.
// R08: Without FIFOs one data write clears the transmit-empty flag.
// R09: Without FIFOs further writes overwrite the pending transmit byte.
// R10: With FIFOs writes are accepted until the transmit FIFO is full.
// R11: A write to a full transmit FIFO is dropped, contents unchanged.
// R12: With divisor access the location is the low divisor byte.
// R13: The divisor is reachable only while divisor access is set.
// R14: Bit rate is clock divided by sixteen times the divisor.
// R15: The high divisor byte sits at the next word under divisor access.
// R16: Otherwise the location is data, and bits 15 to 8 read zero.
// R17: A receive read clears the ready flag once nothing is left.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ud_consts.svh"
module ud_top import ud_pkg::*; #(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16
) (
  input  wire logic        clk_i,            // 50 MHz bus clock.
  input  wire logic        rst_i,            // Async reset, high.
  input  wire logic [31:0] s_axi_awaddr_i,   // Write address.
  input  wire logic        s_axi_awvalid_i,  // Write address valid.
  output logic             s_axi_awready_o,  // Write address ready.
  input  wire logic [31:0] s_axi_wdata_i,    // Write data.
  input  wire logic [3:0]  s_axi_wstrb_i,    // Byte enables.
  input  wire logic        s_axi_wvalid_i,   // Write data valid.
  output logic             s_axi_wready_o,   // Write data ready.
  output logic [1:0]       s_axi_bresp_o,    // Write answer.
  output logic             s_axi_bvalid_o,   // Write answer valid.
  input  wire logic        s_axi_bready_i,   // Write answer taken.
  input  wire logic [31:0] s_axi_araddr_i,   // Read address.
  input  wire logic        s_axi_arvalid_i,  // Read address valid.
  output logic             s_axi_arready_o,  // Read address ready.
  output logic [31:0]      s_axi_rdata_o,    // Read data.
  output logic [1:0]       s_axi_rresp_o,    // Read answer.
  output logic             s_axi_rvalid_o,   // Read answer valid.
  input  wire logic        s_axi_rready_i,   // Read answer taken.
  input  wire logic        rxd_i,            // Serial input line.
  input  wire logic        sir_in_i,         // Infrared pulse input.
  output logic             txd_o,            // Serial output line.
  output logic             sir_out_n_o,      // Infrared output, low.
  output logic             irq_o             // Interrupt level.
);
  localparam int CW_TX = $clog2(TX_DEPTH + 1);
  localparam int CW_RX = $clog2(RX_DEPTH + 1);

  logic [15:0]      div;
  logic [7:0]       line_format;
  logic             fifo_en;
  logic             overrun;
  logic [2:0]       irq_stat;
  logic [2:0]       irq_mask;
  logic             tx_empty_q;
  logic [7:0]       rx_hold;
  logic             rx_hold_valid;
  logic [7:0]       tx_hold;
  logic             tx_hold_full;
  logic             aw_held;
  logic             w_held;
  logic [31:0]      aw_addr;
  logic [7:0]       w_byte;
  logic             w_lane0;
  logic             rd_was_rx;
  logic [15:0]      base_cnt;
  logic [3:0]       ir_stretch;
  ud_state_t        tx_state;
  logic [3:0]       tx_cnt;
  logic [2:0]       tx_bit;
  logic [7:0]       tx_shift;
  ud_state_t        rx_state;
  logic [3:0]       rx_cnt;
  logic [2:0]       rx_bit;
  logic [7:0]       rx_shift;
  logic             rx_done;
  logic             txf_in_ready;
  logic             txf_valid;
  logic [7:0]       txf_data;
  logic [CW_TX-1:0] txf_count;
  logic             rxf_in_ready;
  logic             rxf_valid;
  logic [7:0]       rxf_data;
  logic [CW_RX-1:0] rxf_count;

  // Write decode, done once both address and data are held.
  wire div_access  = line_format[`UD_FMT_DIV_ACCESS];
  wire ir_mode     = line_format[`UD_FMT_IR_MODE];
  wire do_wr       = aw_held && w_held && !s_axi_bvalid_o;
  wire wr_hit_data = aw_addr == `UD_ADDR_DATA;
  wire wr_hit_divh = aw_addr == `UD_ADDR_DIV_HIGH;
  wire wr_hit_fifo = aw_addr == `UD_ADDR_FIFO_CTRL;
  wire wr_hit_fmt  = aw_addr == `UD_ADDR_LINE_FMT;
  wire wr_hit_st   = aw_addr == `UD_ADDR_LINE_ST;
  wire wr_hit_irqs = aw_addr == `UD_ADDR_IRQ_STAT;
  wire wr_hit_mask = aw_addr == `UD_ADDR_IRQ_MASK;
  wire wr_ok       = wr_hit_data | wr_hit_divh | wr_hit_fifo | wr_hit_fmt
                   | wr_hit_st | wr_hit_irqs | wr_hit_mask;
  wire wr_lane     = do_wr && w_lane0;
  wire wr_tx       = wr_lane && wr_hit_data && !div_access; // R16
  wire wr_divl     = wr_lane && wr_hit_data && div_access;  // R12 R13
  wire wr_divh     = wr_lane && wr_hit_divh && div_access;  // R15
  wire wr_fmt      = wr_lane && wr_hit_fmt;
  wire wr_mask     = wr_lane && wr_hit_mask;
  wire flush       = wr_lane && wr_hit_fifo
                   && (w_byte[`UD_FIFO_ENABLE] != fifo_en);

  // Read decode; a read has its side effects in the cycle it is taken.
  wire do_rd       = s_axi_arvalid_i && s_axi_arready_o;
  wire rd_hit_data = s_axi_araddr_i == `UD_ADDR_DATA;
  wire rd_hit_divh = s_axi_araddr_i == `UD_ADDR_DIV_HIGH;
  wire rd_hit_fifo = s_axi_araddr_i == `UD_ADDR_FIFO_CTRL;
  wire rd_hit_fmt  = s_axi_araddr_i == `UD_ADDR_LINE_FMT;
  wire rd_hit_st   = s_axi_araddr_i == `UD_ADDR_LINE_ST;
  wire rd_hit_irqs = s_axi_araddr_i == `UD_ADDR_IRQ_STAT;
  wire rd_hit_mask = s_axi_araddr_i == `UD_ADDR_IRQ_MASK;
  wire rd_ok       = rd_hit_data | rd_hit_divh | rd_hit_fifo | rd_hit_fmt
                   | rd_hit_st | rd_hit_irqs | rd_hit_mask;
  wire rd_rx       = do_rd && rd_hit_data && !div_access;   // R17
  wire rd_st       = do_rd && rd_hit_st;
  wire rd_irqs     = do_rd && rd_hit_irqs;

  // Status seen by software.
  wire [7:0] rx_head  = fifo_en ? rxf_data : rx_hold;        // R01 R04
  wire       rx_ready = fifo_en ? rxf_valid : rx_hold_valid; // R17
  wire       tx_empty = fifo_en ? (txf_count == '0) : !tx_hold_full;
  wire       tx_idle  = (tx_state == UD_IDLE) && tx_empty;
  wire [7:0] line_state = {1'b0, tx_idle, tx_empty, 3'b000, overrun,
                           rx_ready};
  wire [7:0] rd_byte =
      rd_hit_data ? (div_access ? div[7:0] : rx_head) :      // R12 R13
      rd_hit_divh ? (div_access ? div[15:8] : 8'h00) :       // R15
      rd_hit_fifo ? {7'h00, fifo_en} :
      rd_hit_fmt  ? line_format :
      rd_hit_st   ? line_state :
      rd_hit_irqs ? {5'h00, irq_stat} :
      rd_hit_mask ? {5'h00, irq_mask} : 8'h00;

  // Baud tick at sixteen times the bit rate; divisor zero stops it.
  wire tick = (div != 16'h0000) && (base_cnt == div - 16'h0001); // R14

  // Character sources and sinks.
  wire       tx_src_valid = fifo_en ? txf_valid : tx_hold_full;
  wire [7:0] tx_src_data  = fifo_en ? txf_data : tx_hold;
  wire       tx_load      = (tx_state == UD_IDLE) && tx_src_valid;
  wire       tx_line      = (tx_state == UD_START) ? 1'b0 :
                            (tx_state == UD_DATA) ? tx_shift[0] : 1'b1;
  wire       rx_line      = ir_mode ? (ir_stretch == 4'h0) : rxd_i; // R01
  wire       ev_overrun   = rx_done && (fifo_en ? !rxf_in_ready
                                        : (rx_hold_valid && !rd_rx));
  wire [2:0] events       = {tx_empty && !tx_empty_q, ev_overrun,
                             rx_done && !ev_overrun};
  wire [2:0] next_irq_stat = (irq_stat & ~{3{rd_irqs}}) | events;

  ud_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (flush),
    .in_valid_i  (wr_tx && fifo_en),            // R10 R11
    .in_ready_o  (txf_in_ready),
    .in_data_i   (w_byte),
    .out_valid_o (txf_valid),
    .out_ready_i (tx_load && fifo_en),
    .out_data_o  (txf_data),
    .count_o     (txf_count)
  );

  ud_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (flush),
    .in_valid_i  (rx_done && fifo_en),          // R05
    .in_ready_o  (rxf_in_ready),
    .in_data_i   (rx_shift),
    .out_valid_o (rxf_valid),
    .out_ready_i (rd_rx && fifo_en),            // R04
    .out_data_o  (rxf_data),
    .count_o     (rxf_count)
  );

  // Write side of the bus; one write in flight, new address after answer.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `UD_RESP_OKAY;
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 32'h0000_0000;
      w_byte          <= 8'h00;
      w_lane0         <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held         <= 1'b1;
        aw_addr         <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held         <= 1'b1;
        w_byte         <= s_axi_wdata_i[7:0];
        w_lane0        <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end
      if (do_wr) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_ok ? `UD_RESP_OKAY : `UD_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Read side of the bus; data is captured as the address is taken.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `UD_RESP_OKAY;
      rd_was_rx       <= 1'b0;
    end else if (do_rd) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= {24'h00_0000, rd_byte};    // R16
      s_axi_rresp_o   <= rd_ok ? `UD_RESP_OKAY : `UD_RESP_SLVERR;
      rd_was_rx       <= rd_hit_data && !div_access;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
    end
  end

  // Configuration and interrupt registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div         <= `UD_RST_DIV;
      line_format <= `UD_RST_LINE_FMT;
      fifo_en     <= 1'b0;
      irq_mask    <= `UD_RST_IRQ_MASK;
      irq_stat    <= 3'h0;
      irq_o       <= 1'b0;
      tx_empty_q  <= 1'b1;
    end else begin
      if (wr_divl) div[7:0] <= w_byte;                 // R12 R13
      if (wr_divh) div[15:8] <= w_byte;                // R15
      if (wr_fmt) line_format <= w_byte;
      if (flush) fifo_en <= w_byte[`UD_FIFO_ENABLE];
      if (wr_mask) irq_mask <= w_byte[2:0];
      irq_stat   <= next_irq_stat;
      irq_o      <= |(next_irq_stat & irq_mask);
      tx_empty_q <= tx_empty;
    end
  end

  // Holding bytes and overrun; a new event beats a clearing read.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_hold       <= 8'h00;
      rx_hold_valid <= 1'b0;
      tx_hold       <= 8'h00;
      tx_hold_full  <= 1'b0;
      overrun       <= 1'b0;
    end else begin
      if (rx_done && !fifo_en) begin
        rx_hold       <= rx_shift;                     // R01 R03
        rx_hold_valid <= 1'b1;
      end else if (rd_rx && !fifo_en) begin
        rx_hold_valid <= 1'b0;                         // R17
      end
      if (wr_tx && !fifo_en) begin
        tx_hold      <= w_byte;                        // R09
        tx_hold_full <= 1'b1;                          // R08
      end else if (tx_load && !fifo_en) begin
        tx_hold_full <= 1'b0;
      end
      overrun <= ev_overrun | (overrun & !rd_st);       // R03 R05
    end
  end

  // Baud divider and infrared pulse stretcher.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_cnt   <= 16'h0000;
      ir_stretch <= 4'h0;
    end else begin
      if (div == 16'h0000 || base_cnt >= div - 16'h0001) begin
        base_cnt <= 16'h0000;                          // R14
      end else begin
        base_cnt <= base_cnt + 16'h0001;
      end
      if (sir_in_i) begin
        ir_stretch <= `UD_TICKS_LAST;
      end else if (tick && ir_stretch != 4'h0) begin
        ir_stretch <= ir_stretch - 4'h1;
      end
    end
  end

  // Transmitter: start bit, eight data bits LSB first, one stop bit.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state <= UD_IDLE;
      tx_cnt   <= 4'h0;
      tx_bit   <= 3'h0;
      tx_shift <= 8'h00;
    end else begin
      if (tick) tx_cnt <= tx_cnt + 4'h1;
      unique case (tx_state)
        UD_IDLE: begin
          tx_cnt <= 4'h0;
          if (tx_load) begin
            tx_state <= UD_START;
            tx_shift <= tx_src_data;
          end
        end
        UD_START: begin
          tx_bit <= 3'h0;
          if (tick && tx_cnt == `UD_TICKS_LAST) tx_state <= UD_DATA;
        end
        UD_DATA: begin
          if (tick && tx_cnt == `UD_TICKS_LAST) begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit   <= tx_bit + 3'h1;
            if (tx_bit == 3'h7) tx_state <= UD_STOP;
          end
        end
        UD_STOP: begin
          if (tick && tx_cnt == `UD_TICKS_LAST) tx_state <= UD_IDLE;
        end
      endcase
    end
  end

  // Line drivers; infrared sends a short low pulse for each zero bit.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      txd_o       <= 1'b1;
      sir_out_n_o <= 1'b1;
    end else begin
      txd_o       <= ir_mode ? 1'b1 : tx_line;              // R06
      sir_out_n_o <= !(ir_mode && !tx_line && tx_cnt < `UD_IR_PULSE);
    end
  end

  // Receiver: start bit checked at mid-bit, then one sample per bit.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state <= UD_IDLE;
      rx_cnt   <= 4'h0;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) rx_cnt <= rx_cnt + 4'h1;
      unique case (rx_state)
        UD_IDLE: begin
          rx_cnt <= 4'h0;
          if (!rx_line) rx_state <= UD_START;
        end
        UD_START: begin
          rx_bit <= 3'h0;
          if (tick && rx_cnt == `UD_TICKS_MID) begin
            rx_cnt   <= 4'h0;
            rx_state <= rx_line ? UD_IDLE : UD_DATA;
          end
        end
        UD_DATA: begin
          if (tick && rx_cnt == `UD_TICKS_LAST) begin
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) rx_state <= UD_STOP;
          end
        end
        UD_STOP: begin
          if (tick && rx_cnt == `UD_TICKS_LAST) begin
            rx_state <= UD_IDLE;
            rx_done  <= 1'b1;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tx_begin;
    tx_load && !ir_mode && !wr_fmt ##1 !wr_fmt [*2];
  endsequence

  a_rx_capture: assert property (rx_done && !fifo_en |=> // R01
    rx_hold_valid && rx_hold == $past(rx_shift)) else $error("rx lost");
  a_rx_overwrite: assert property (ev_overrun && !fifo_en |=> // R03
    overrun) else $error("overwrite without overrun");
  a_rx_head_pop: assert property (rd_rx && fifo_en && rxf_valid // R04
    && !rx_done && !flush |=> rxf_count == $past(rxf_count) - 1'b1)
    else $error("head not popped");
  a_rx_full_drop: assert property (rx_done && fifo_en // R05
    && !rxf_in_ready && !rd_rx && !flush
    |=> overrun && rxf_count == $past(rxf_count))
    else $error("full fifo changed");
  a_tx_start_bit: assert property (s_tx_begin |-> !txd_o) // R06
    else $error("no start bit");
  a_tx_empty_clr: assert property (wr_tx && !fifo_en |=> // R08
    !line_state[`UD_ST_TX_EMPTY]) else $error("empty flag kept");
  a_tx_overwrite: assert property (wr_tx && !fifo_en |=> // R09
    tx_hold == $past(w_byte)) else $error("byte not replaced");
  a_tx_fifo_fill: assert property (wr_tx && fifo_en && txf_in_ready // R10
    && !tx_load && !flush |=> txf_count == $past(txf_count) + 1'b1)
    else $error("write not queued");
  a_tx_full_drop: assert property (wr_tx && fifo_en && !txf_in_ready // R11
    && !tx_load && !flush |=> txf_count == $past(txf_count))
    else $error("full fifo grew");
  a_div_low_wr: assert property (wr_divl |=> // R12
    div[7:0] == $past(w_byte)) else $error("divisor low not written");
  a_div_gated: assert property (!wr_divl && !wr_divh |=> // R13
    $stable(div)) else $error("divisor changed without access");
  a_tick_rate: assert property (tick |-> base_cnt == div - 16'h0001 // R14
    ##1 !tick || div == 16'h0001) else $error("tick spacing wrong");
  a_upper_zero: assert property (s_axi_rvalid_o && rd_was_rx |-> // R16
    s_axi_rdata_o[15:8] == 8'h00) else $error("upper byte not zero");
  a_ready_clear: assert property (rd_rx && !fifo_en && !rx_done |=> // R17
    !rx_ready) else $error("ready flag kept");

endmodule : ud_top

// ---- dv/ud_peer.sv ----
`timescale 1ns/1ps
// Far-end serial peer: 8N1, LSB first, BIT clocks per bit cell.
module ud_peer #(
  parameter int BIT = 16
) (
  input  wire logic clk_i, // Bus clock.
  input  wire logic txd_i, // Line from the block.
  output logic      rxd_o  // Line into the block.
);
  logic [7:0] got;
  int         cnt;
  // The line idles high, as the pulled-up wire would.
  initial begin
    rxd_o = 1'b1;
    got = 8'h00;
    cnt = 0;
  end
  // Sends one whole frame; the caller waits for it to end.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
  endtask : send
  // Samples mid-cell, so a wrong bit rate corrupts the byte.
  always begin
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      got[i] = txd_i;
    end
    repeat (BIT) @(posedge clk_i);
    cnt++;
  end
endmodule : ud_peer

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`include "ud_consts.svh"
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0;
  logic ar_v = 1'b0, r_r = 1'b0, aw_rdy, w_rdy, b_v, ar_rdy, r_v, txd;
  logic rxd, sir_n, irq, sir = 1'b0;
  logic [3:0]  w_s = 4'h1;
  logic [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0, r_d;
  logic [1:0]  b_rsp, r_rsp;
  int          errors = 0, cmp_count = 0, n;
  // Clock of 50 MHz.
  always #10 clk_i = ~clk_i;
  // Infrared loopback: each low pulse sent comes back as a high pulse.
  always @(posedge clk_i) sir <= !sir_n;
  // A small receive FIFO lets a short run reach the full case.
  ud_top #(.TX_DEPTH(16), .RX_DEPTH(2)) ud_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(aw_a),
    .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy),
    .s_axi_wdata_i(w_d), .s_axi_wstrb_i(w_s), .s_axi_wvalid_i(w_v),
    .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_rsp), .s_axi_bvalid_o(b_v),
    .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
    .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_rsp),
    .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r), .rxd_i(rxd),
    .sir_in_i(sir), .txd_o(txd), .sir_out_n_o(sir_n), .irq_o(irq));
  ud_peer #(.BIT(16)) ud_peer_inst (.clk_i(clk_i), .txd_i(txd),
    .rxd_o(rxd));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Each channel is released at the edge where its ready is seen.
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_i);
    aw_a <= a;
    w_d <= {24'h0, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge clk_i);
      if (aw_rdy === 1'b1) aw_v <= 1'b0;
      if (w_rdy === 1'b1) w_v <= 1'b0;
    end while (b_v !== 1'b1);
    b_r <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, m, e);
    @(posedge clk_i);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge clk_i);
      if (ar_rdy === 1'b1) ar_v <= 1'b0;
    end while (r_v !== 1'b1);
    r_r <= 1'b0;
    chk(r_d & m, e);
  endtask : rd
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end
  // Main sequence; the flag reads stand in for software polling.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`UD_ADDR_DATA, 32'hFFFFFFFF, 32'h0);
    rd(`UD_ADDR_LINE_ST, 32'h20, 32'h20);
    rd(32'h5000_1080, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, r_rsp}, {30'h0, `UD_RESP_SLVERR});
    $display("test reset done");
    // A write whose low byte lane is off must leave the register alone.
    w_s <= 4'h0;
    wr(`UD_ADDR_LINE_FMT, 8'h80);
    w_s <= 4'h1;
    rd(`UD_ADDR_LINE_FMT, 32'hFF, 32'h0);
    wr(`UD_ADDR_LINE_FMT, 8'h80);
    wr(`UD_ADDR_DATA, 8'h01);
    wr(`UD_ADDR_DIV_HIGH, 8'h00);
    rd(`UD_ADDR_DATA, 32'hFFFFFFFF, 32'h1);
    wr(`UD_ADDR_LINE_FMT, 8'h00);
    wr(`UD_ADDR_DIV_HIGH, 8'hFF);
    rd(`UD_ADDR_DIV_HIGH, 32'hFF, 32'h0);
    rd(`UD_ADDR_DATA, 32'hFFFFFFFF, 32'h0);
    $display("test divisor done");
    n = ud_peer_inst.cnt;
    // The second byte waits in holding and is replaced by the third.
    wr(`UD_ADDR_DATA, 8'hA5);
    wr(`UD_ADDR_DATA, 8'h5A);
    rd(`UD_ADDR_LINE_ST, 32'h20, 32'h0);
    wr(`UD_ADDR_DATA, 8'hC3);
    wait (ud_peer_inst.cnt == n + 1);
    chk({24'h0, ud_peer_inst.got}, 32'hA5);
    wait (ud_peer_inst.cnt == n + 2);
    chk({24'h0, ud_peer_inst.got}, 32'hC3);
    $display("test transmit done");
    wr(`UD_ADDR_IRQ_MASK, 8'h01);
    ud_peer_inst.send(8'h3C);
    repeat (4) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    rd(`UD_ADDR_IRQ_STAT, 32'h1, 32'h1);
    @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    rd(`UD_ADDR_LINE_ST, 32'h1, 32'h1);
    rd(`UD_ADDR_DATA, 32'hFFFFFFFF, 32'h3C);
    rd(`UD_ADDR_LINE_ST, 32'h1, 32'h0);
    $display("test receive done");
    ud_peer_inst.send(8'h11);
    ud_peer_inst.send(8'h22);
    repeat (4) @(posedge clk_i);
    rd(`UD_ADDR_DATA, 32'hFF, 32'h22);
    rd(`UD_ADDR_LINE_ST, 32'h2, 32'h2);
    $display("test overrun done");
    wr(`UD_ADDR_FIFO_CTRL, 8'h01);
    ud_peer_inst.send(8'h44);
    ud_peer_inst.send(8'h55);
    ud_peer_inst.send(8'h66);
    repeat (4) @(posedge clk_i);
    rd(`UD_ADDR_DATA, 32'hFF, 32'h44);
    rd(`UD_ADDR_DATA, 32'hFF, 32'h55);
    rd(`UD_ADDR_LINE_ST, 32'h3, 32'h2);
    $display("test fifo done");
    // Infrared mode: the byte loops back and the wired line stays idle.
    n = ud_peer_inst.cnt;
    wr(`UD_ADDR_LINE_FMT, 8'h01);
    wr(`UD_ADDR_DATA, 8'h5A);
    repeat (200) @(posedge clk_i);
    rd(`UD_ADDR_DATA, 32'hFF, 32'h5A);
    chk(ud_peer_inst.cnt, n);
    $display("test infrared done");
    // One byte goes to the shifter, sixteen fill the queue, one is lost.
    repeat (18) wr(`UD_ADDR_DATA, 8'h77);
    rd(`UD_ADDR_LINE_ST, 32'h20, 32'h0);
    $display("test transmit fifo done");
    tally_and_finish();
  end
endmodule : tb
